// ==== common/dac_frame_map.svh ====
`ifndef DAC_FRAME_MAP_SVH
`define DAC_FRAME_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CTRL_OFS 4'h0
`define INPUT_OFS 4'h4
`define DACREG_OFS 4'h8
`define STATUS_OFS 4'hC

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CTRL_RST 3'h0
`define ZERO_CODE 12'h000
`define MID_CODE 12'h800

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define LAST_BIT 5'h0F
`define READBACK_BITS 5'h10
`define CMD_MSB 15
`define CMD_LSB 12
`define CMD_NOP 4'h0
`define CMD_WR_A 4'h1
`define CMD_WR_B 4'h2
`define CMD_READBACK 4'h3
`define CMD_CTRL 4'h4
`define RB_SEL_BIT 0

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define CTRL_RISE_BIT 0
`define CTRL_DAISY_BIT 1
`define CTRL_MID_BIT 2
`define STAT_OVF_BIT 0
`define STAT_FRAME_BIT 1
`define STAT_LVL_LSB 4

`endif

// ==== common/dac_frame_pkg.sv ====
package dac_frame_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic midscale;
      logic daisy;
      logic rising;
   } ctrl_t;

   typedef struct packed {
      logic [11:0] b;
      logic [11:0] a;
   } dac_pair_t;

   typedef enum logic [2:0] {
      LINK_IDLE = 3'b001,
      LINK_SHIFT = 3'b010,
      LINK_HOLD = 3'b100
   } link_state_t;

endpackage : dac_frame_pkg

// ==== test/dac_frame_clear_tb.sv ====
`include "dac_frame_map.svh"

module dac_frame_clear_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0000_0000;
   logic [31:0] wb_rdat;
   logic wb_ack;
   logic frame_n;
   logic sclk;
   logic serial_data_in;
   logic sdout;
   logic clear_n = 1'b1;
   logic load_n = 1'b1;
   dac_frame_pkg::dac_pair_t dac_code;
   logic [15:0] rb;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;

   dac_frame_clear i_dac_frame_clear (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .frame_n_i(frame_n), .sclk_i(sclk), .serial_data_in_i(serial_data_in), .serial_data_out_o(sdout),
      .clear_n_i(clear_n), .load_update_n_i(load_n), .dac_code_o(dac_code));

   serial_host i_serial_host (
      .clk_i(clk_i), .frame_n_o(frame_n), .sclk_o(sclk), .sdata_o(serial_data_in), .sdo_i(sdout));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
                          output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= s;
      wb_wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 16);
      q = wb_rdat;
      if (wb_ack !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: no bus answer", $time);
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb_xfer

   task automatic wb_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] q;
      wb_xfer(1'b1, a, s, d, q);
   endtask : wb_wr

   task automatic wb_rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
      check(q, exp);
   endtask : wb_rd

   // Limit sized well above the few thousand cycles the sequence needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         $display("mismatch at %0t: run timed out", $time);
         complete_run();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb_rd(`CTRL_OFS, 32'h0000_0000);
      wb_rd(`STATUS_OFS, 32'h0000_0000);
      wb_wr(4'h2, 32'hFFFF_FFFF);
      // Lane 0 disabled, so the control write must be ignored
      wb_wr(`CTRL_OFS, 32'h0000_0007, 4'hE);
      wb_rd(4'h2, 32'h0000_0000);
      wb_rd(`CTRL_OFS, 32'h0000_0000);
      i_serial_host.frame16(16'h1ABC);
      i_serial_host.frame16(16'h2345);
      i_serial_host.frame16(16'h0FFF);
      wb_rd(`INPUT_OFS, 32'h0345_0ABC);
      check({8'h00, dac_code}, 32'h0000_0000);
      i_serial_host.idle_noise(40);
      wb_rd(`INPUT_OFS, 32'h0345_0ABC);
      load_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      load_n <= 1'b1;
      repeat (2) @(posedge clk_i);
      check({8'h00, dac_code}, 32'h0034_5ABC);
      wb_rd(`DACREG_OFS, 32'h0345_0ABC);
      i_serial_host.frame32({16'h3000, 16'h0000}, rb);
      check({16'h0000, rb}, 32'h0000_0ABC);
      i_serial_host.frame32({16'h3001, 16'h0000}, rb);
      check({16'h0000, rb}, 32'h0000_0345);
      wb_wr(`CTRL_OFS, 32'h0000_0001);
      i_serial_host.rise_act = 1'b1;
      i_serial_host.frame16(16'h1555);
      wb_rd(`INPUT_OFS, 32'h0345_0555);
      i_serial_host.rise_act = 1'b0;
      wb_wr(`CTRL_OFS, 32'h0000_0002);
      i_serial_host.frame32({16'h1234, 16'h1777}, rb);
      check({16'h0000, rb}, 32'h0000_1234);
      wb_rd(`INPUT_OFS, 32'h0345_0777);
      wb_wr(`CTRL_OFS, 32'h0000_0000);
      load_n <= 1'b0;
      i_serial_host.frame16(16'h2222);
      repeat (4) @(posedge clk_i);
      check({8'h00, dac_code}, 32'h0022_2777);
      load_n <= 1'b1;
      clear_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      check({8'h00, dac_code}, 32'h0000_0000);
      wb_rd(`INPUT_OFS, 32'h0000_0000);
      clear_n <= 1'b1;
      i_serial_host.frame16(16'h4004);
      wb_rd(`CTRL_OFS, 32'h0000_0004);
      clear_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      check({8'h00, dac_code}, 32'h0080_0800);
      wb_rd(`INPUT_OFS, 32'h0800_0800);
      // Clear stalls the drain: four words wait, the fifth is dropped
      i_serial_host.frame16(16'h1111);
      i_serial_host.frame16(16'h1222);
      i_serial_host.frame16(16'h1333);
      i_serial_host.frame16(16'h1444);
      i_serial_host.frame16(16'h2456);
      wb_rd(`STATUS_OFS, 32'h0000_0041);
      wb_wr(`STATUS_OFS, 32'h0000_0001);
      wb_rd(`STATUS_OFS, 32'h0000_0040);
      wb_rd(`INPUT_OFS, 32'h0800_0800);
      clear_n <= 1'b1;
      repeat (8) @(posedge clk_i);
      wb_rd(`INPUT_OFS, 32'h0800_0444);
      wb_rd(`STATUS_OFS, 32'h0000_0000);
      // Reset in mid-run must bring the control, input and converter registers back to zero
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      check({8'h00, dac_code}, 32'h0000_0000);
      wb_rd(`CTRL_OFS, 32'h0000_0000);
      wb_rd(`INPUT_OFS, 32'h0000_0000);
      i_serial_host.frame16(16'h1321);
      wb_rd(`INPUT_OFS, 32'h0000_0321);
      complete_run();
   end
endmodule : dac_frame_clear_tb

// ==== test/serial_host.sv ====
module serial_host (
   // Clock
   input wire logic clk_i,
   // Link pins
   output logic frame_n_o,
   output logic sclk_o,
   output logic sdata_o,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 1ns;

   logic rise_act = 1'b0;

   initial begin
      frame_n_o = 1'b1;
      sclk_o = 1'b1;
      sdata_o = 1'b0;
   end

   // Released data line toggles so a stale bit never looks driven
   always @(posedge clk_i) begin
      if (frame_n_o) begin
         sdata_o <= ~sdata_o;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // Data moves between the edges, so this bit is seen by the selected edge and by the next opposite edge
   task automatic bit_io(input logic b, inout logic [15:0] cap);
      if (!rise_act) sdata_o <= b;
      tick(2);
      sclk_o <= 1'b0;
      tick(2);
      if (rise_act) sdata_o <= b;
      cap = {cap[14:0], sdo_i};
      tick(2);
      sclk_o <= 1'b1;
      tick(2);
   endtask : bit_io

   task automatic frame_io(input logic [31:0] w, input int n, output logic [15:0] got);
      got = 16'h0000;
      frame_n_o <= 1'b0;
      tick(4);
      for (int i = 31; i > 31 - n; i--) bit_io(w[i], got);
      tick(2);
      frame_n_o <= 1'b1;
      tick(4);
   endtask : frame_io

   task automatic frame16(input logic [15:0] w);
      logic [15:0] unused;
      frame_io({w, 16'h0000}, 16, unused);
   endtask : frame16

   task automatic frame32(input logic [31:0] w, output logic [15:0] got);
      frame_io(w, 32, got);
   endtask : frame32

   // Clock activity with frame high, which must be ignored
   task automatic idle_noise(input int n);
      repeat (n) begin
         sclk_o <= ~sclk_o;
         tick(2);
      end
      sclk_o <= 1'b1;
      tick(4);
   endtask : idle_noise
endmodule : serial_host

// ==== verilog/dac_frame_clear.sv ====
`include "dac_frame_map.svh"

module dac_frame_clear
   import dac_frame_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial link pins
   input wire logic frame_n_i,
   input wire logic sclk_i,
   input wire logic serial_data_in_i,
   output logic serial_data_out_o,
   // Control pins
   input wire logic clear_n_i,
   input wire logic load_update_n_i,
   // Converter codes
   output dac_pair_t dac_code_o
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic sclk_d_r;
   logic frame_d_r;
   logic load_d_r;
   logic frame_n_s;
   logic sclk_s;
   logic serial_data_in_s;
   logic clear_n_s;
   logic load_n_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 5'h1F;
         sync2_r <= 5'h1F;
         sclk_d_r <= 1'b1;
         frame_d_r <= 1'b1;
         load_d_r <= 1'b1;
      end else begin
         sync1_r <= {load_update_n_i, clear_n_i, serial_data_in_i, sclk_i, frame_n_i};
         sync2_r <= sync1_r;
         sclk_d_r <= sync2_r[1];
         frame_d_r <= sync2_r[0];
         load_d_r <= sync2_r[4];
      end
   end

   assign frame_n_s = sync2_r[0];
   assign sclk_s = sync2_r[1];
   assign serial_data_in_s = sync2_r[2];
   assign clear_n_s = sync2_r[3];
   assign load_n_s = sync2_r[4];

   // ----------------------------------------
   // Edge decode
   // ----------------------------------------
   ctrl_t ctrl_r;
   logic sclk_rise;
   logic sclk_fall;
   logic act_edge;
   logic out_edge;
   logic frame_fall;
   logic frame_rise;
   logic load_fall;

   assign sclk_rise = sclk_s && !sclk_d_r;
   assign sclk_fall = !sclk_s && sclk_d_r;
   assign act_edge = ctrl_r.rising ? sclk_rise : sclk_fall;
   assign out_edge = ctrl_r.rising ? sclk_fall : sclk_rise;
   assign frame_fall = !frame_n_s && frame_d_r;
   assign frame_rise = frame_n_s && !frame_d_r;
   assign load_fall = !load_n_s && load_d_r;

   // ----------------------------------------
   // Input shift register
   // ----------------------------------------
   link_state_t state_r;
   logic [15:0] shreg_r;
   logic [4:0] bit_cnt_r;
   logic shift_en;
   logic [15:0] word_in;
   logic push_word;
   logic fifo_ready;
   logic ovf_set;

   // Disabled while frame is high or after a standalone word is complete
   assign shift_en = act_edge && !frame_n_s && (state_r == LINK_SHIFT);
   assign word_in = {shreg_r[14:0], serial_data_in_s};
   assign push_word = ctrl_r.daisy ? (frame_rise && state_r == LINK_SHIFT)
                                   : (shift_en && bit_cnt_r == `LAST_BIT);
   assign ovf_set = push_word && !fifo_ready;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= LINK_IDLE;
         bit_cnt_r <= '0;
      end else begin
         case (state_r)
            LINK_IDLE: begin
               if (frame_fall) begin
                  state_r <= LINK_SHIFT;
                  bit_cnt_r <= '0;
               end
            end
            LINK_SHIFT: begin
               if (frame_n_s) begin
                  state_r <= LINK_IDLE;
               end else if (shift_en) begin
                  bit_cnt_r <= bit_cnt_r + 5'h01;
                  if (!ctrl_r.daisy && bit_cnt_r == `LAST_BIT) begin
                     state_r <= LINK_HOLD;
                  end
               end
            end
            LINK_HOLD: begin
               if (frame_n_s) begin
                  state_r <= LINK_IDLE;
               end
            end
            default: state_r <= LINK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shreg_r <= '0;
      end else if (shift_en) begin
         shreg_r <= word_in;
      end
   end

   // ----------------------------------------
   // Word buffer
   // ----------------------------------------
   logic [15:0] fifo_word;
   logic fifo_valid;
   logic [2:0] fifo_level;
   logic [15:0] push_data;

   assign push_data = ctrl_r.daisy ? shreg_r : word_in;

   // Drain stalls while clear is held, so up to four words wait; a word pushed into a full buffer is lost
   word_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(push_word),
      .in_ready_o(fifo_ready),
      .in_data_i(push_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(clear_n_s),
      .out_data_o(fifo_word),
      .level_o(fifo_level)
   );

   // ----------------------------------------
   // Input and converter registers
   // ----------------------------------------
   dac_pair_t in_r;
   dac_pair_t dac_r;
   logic [11:0] clr_code;
   logic apply;
   logic [3:0] cmd;
   logic wb_ctrl_wr;

   assign clr_code = ctrl_r.midscale ? `MID_CODE : `ZERO_CODE;
   assign apply = fifo_valid && clear_n_s;
   assign cmd = fifo_word[`CMD_MSB:`CMD_LSB];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_r <= '0;
         dac_r <= '0;
      end else if (!clear_n_s) begin
         in_r <= {clr_code, clr_code};
         dac_r <= {clr_code, clr_code};
      end else begin
         if (load_fall) begin
            dac_r <= in_r;
         end
         if (apply && cmd == `CMD_WR_A) begin
            in_r.a <= fifo_word[11:0];
            if (!load_n_s) begin
               dac_r.a <= fifo_word[11:0];
            end
         end
         if (apply && cmd == `CMD_WR_B) begin
            in_r.b <= fifo_word[11:0];
            if (!load_n_s) begin
               dac_r.b <= fifo_word[11:0];
            end
         end
      end
   end

   assign dac_code_o = dac_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= `CTRL_RST;
      end else if (wb_ctrl_wr) begin
         ctrl_r <= wb_dat_i[2:0];
      end else if (apply && cmd == `CMD_CTRL) begin
         ctrl_r <= fifo_word[2:0];
      end
   end

   // ----------------------------------------
   // Serial data out and readback
   // ----------------------------------------
   logic [15:0] rb_sh_r;
   logic [4:0] rb_cnt_r;
   logic sdo_r;
   logic rb_start;

   // Readback is caught straight off the shifter so it leaves on the very next opposite edge
   assign rb_start = push_word && !ctrl_r.daisy && word_in[`CMD_MSB:`CMD_LSB] == `CMD_READBACK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rb_sh_r <= '0;
         rb_cnt_r <= '0;
         sdo_r <= 1'b0;
      end else if (rb_start) begin
         rb_sh_r <= {4'h0, word_in[`RB_SEL_BIT] ? dac_r.b : dac_r.a};
         rb_cnt_r <= `READBACK_BITS;
      end else if (out_edge && !frame_n_s) begin
         if (rb_cnt_r != '0) begin
            sdo_r <= rb_sh_r[15];
            rb_sh_r <= {rb_sh_r[14:0], 1'b0};
            rb_cnt_r <= rb_cnt_r - 5'h01;
         end else begin
            sdo_r <= shreg_r[15];
         end
      end
   end

   assign serial_data_out_o = sdo_r;

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic ack_r;
   logic [31:0] rdat_r;
   logic ovf_r;
   logic req;

   assign req = wb_cyc_i && wb_stb_i;
   assign wb_ctrl_wr = req && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == `CTRL_OFS;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r <= req && !ack_r;
         if (req && !ack_r) begin
            case (wb_adr_i)
               `CTRL_OFS: rdat_r <= {29'h0, ctrl_r};
               `INPUT_OFS: rdat_r <= {4'h0, in_r.b, 4'h0, in_r.a};
               `DACREG_OFS: rdat_r <= {4'h0, dac_r.b, 4'h0, dac_r.a};
               `STATUS_OFS: rdat_r <= {25'h0, fifo_level, 2'h0, !frame_n_s, ovf_r};
               default: rdat_r <= '0;
            endcase
         end
      end
   end

   // Overflow is sticky, write one to clear; a new overflow wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_r <= 1'b0;
      end else if (ovf_set) begin
         ovf_r <= 1'b1;
      end else if (req && ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == `STATUS_OFS
                   && wb_dat_i[`STAT_OVF_BIT]) begin
         ovf_r <= 1'b0;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Active edges in a frame, counted apart from the shifter so the latch check does not lean on bit_cnt_r
   logic [4:0] edge_tally_r;

   always_ff @(posedge clk_i) begin
      if (rst_i || frame_fall) begin
         edge_tally_r <= '0;
      end else if (act_edge && !frame_n_s && edge_tally_r != 5'h1F) begin
         edge_tally_r <= edge_tally_r + 5'h01;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_frame_opens_shift: assert property (state_r == LINK_IDLE && frame_fall |=>
      state_r == LINK_SHIFT && bit_cnt_r == 5'h00) else $error("frame fall did not open shifting");
   a_bit_shifted_in: assert property (shift_en |=> shreg_r[0] == $past(serial_data_in_s)
      && shreg_r[15:1] == $past(shreg_r[14:0])) else $error("bit not shifted in");
   a_word_on_sixteen: assert property (push_word && !ctrl_r.daisy |->
      edge_tally_r == 5'h0F && act_edge) else $error("standalone latch not on sixteenth edge");
   a_latch_taken: assert property (state_r == LINK_SHIFT && shift_en && !ctrl_r.daisy
      && edge_tally_r == 5'h0F |-> push_word) else $error("sixteenth edge did not latch the word");
   a_clear_value: assert property (!clear_n_s |=>
      in_r == {$past(clr_code), $past(clr_code)} && dac_r == in_r) else $error("clear value wrong");
   a_edge_select: assert property (shift_en |->
      (ctrl_r.rising ? (sclk_s && !sclk_d_r) : (!sclk_s && sclk_d_r))) else $error("wrong sample edge");
   a_sdo_opposite: assert property (!(out_edge && !frame_n_s) |=> $stable(sdo_r))
      else $error("data out moved off the opposite edge");
   a_load_update: assert property (load_fall && clear_n_s && !apply |=> dac_r == $past(in_r))
      else $error("load fall did not update converter");
   a_readback_len: assert property (rb_start |=> rb_cnt_r == 5'h10 ##1 rb_cnt_r <= 5'h10)
      else $error("readback count wrong");
   a_idle_frozen: assert property (frame_n_s |=> $stable(shreg_r))
      else $error("shift register moved outside frame");

   c_word_pushed: cover property (push_word && fifo_ready);
   c_readback: cover property (rb_start ##[1:400] rb_cnt_r == 5'h00);
   c_overflow: cover property (ovf_set);
   c_load_fall: cover property (load_fall && clear_n_s);

endmodule : dac_frame_clear

// ==== verilog/word_fifo.sv ====
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [$clog2(DEPTH+1)-1:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid_o = (cnt_r != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_r[rd_r];
   assign level_o = cnt_r;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end

endmodule : word_fifo
